//--- include/fop_pkg.sv
// Constants, field positions, states and carriers of the flash option and protection block.
// Assumes one 100 MHz clock domain, a byte-wide array with one-cycle read latency and
// an AHB-Lite master that issues single whole-word transfers.
// Behaviour
// RULE1: Information area sits at FE00H-FFFFH; only part readable, never programmed or erased.
// RULE2: Sequencer times byte program, page erase and mass erase strobes.
// RULE3: Program and erase need the selected page, an open sector and the unlock key; mass erase checks no page and needs every sector open.
// RULE4: Option bit 3 clear lets brown-out stop in stop mode when power bit set.
// RULE5: Option bit 3 set keeps brown-out enabled in every mode; erased value does so.
// RULE6: Option bit 2 clear hides user code and limits debug port commands.
// RULE7: Option bit 2 set, the erased value, opens code and all debug commands.
// RULE8: Whoever programs option bits writes 1 into reserved bit 1.
// RULE9: Option bit 0 clear refuses user program and erase; debug mass erase still works.
// RULE10: Option bit 0 set allows program, page erase and mass erase in program memory.
// RULE11: Option byte at address 0001H is only read, never altered by reset.
// RULE12: Options are read from the array after reset and latched before any operation.
package fop_pkg;
	localparam int CLK_MHZ = 100;
	localparam int PROG_TIME_US = 20;
	localparam int PERASE_TIME_US = 1000;
	localparam int MERASE_TIME_US = 2000;
	localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
	localparam int PERASE_CYC = PERASE_TIME_US * CLK_MHZ;
	localparam int MERASE_CYC = MERASE_TIME_US * CLK_MHZ;

	localparam logic [15:0] OPT_ADDR = 16'h0001;
	localparam logic [15:0] PMEM_LAST = 16'h3fff;
	localparam logic [15:0] INFO_BASE = 16'hfe00;
	localparam logic [15:0] INFO_LAST = 16'hffff;
	localparam logic [15:0] INFO_ACC_LAST = 16'hfe7f;
	localparam int PAGE_LSB = 9;
	localparam int SECT_LSB = 11;
	localparam int SECT_MSB = 13;

	localparam int OPT_WP_BIT = 0;
	localparam int OPT_RSV_BIT = 1;
	localparam int OPT_RP_BIT = 2;
	localparam int OPT_BO_BIT = 3;
	localparam logic [7:0] OPT_RESET = 8'hff;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_KEY = 8'h14;
	localparam logic [7:0] REG_PAGE = 8'h18;
	localparam logic [7:0] REG_SECT = 8'h1c;
	localparam logic [7:0] KEY_FIRST = 8'h5a;
	localparam logic [7:0] KEY_SECOND = 8'ha5;

	localparam logic [2:0] CMD_READ = 3'h1;
	localparam logic [2:0] CMD_PROG = 3'h2;
	localparam logic [2:0] CMD_PERASE = 3'h3;
	localparam logic [2:0] CMD_MERASE = 3'h4;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_READ, ST_READ_WAIT, ST_RUN} fop_state_t;

	typedef struct packed {
		logic rd;
		logic prog;
		logic page_erase;
		logic mass_erase;
		logic [15:0] addr;
		logic [7:0] wdata;
	} fop_flash_req_t;

	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [31:0] data;
	} fop_bus_wr_t;

	typedef struct packed {
		logic wr_pend;
		logic rd_pend;
		logic hit;
		logic [7:0] addr;
		logic [31:0] hrdata;
	} fop_ahb_st_t;

	typedef struct packed {
		fop_state_t st;
		fop_flash_req_t req;
		logic [23:0] cnt;
		logic [7:0] opts;
		logic opt_valid;
		logic loading;
		logic [2:0] cmd;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic [6:0] page;
		logic [7:0] sect;
		logic key_stage;
		logic unlocked;
		logic done;
		logic refused;
		logic dbg_pend;
		logic bo_en;
		logic rd_en;
	} fop_ctrl_st_t;

	localparam fop_ctrl_st_t CTRL_RST = '{st: ST_LOAD, opts: OPT_RESET, bo_en: 1'b1,
		rd_en: 1'b1, default: '0};
endpackage

//--- src/fop_ahb_slave.sv
// AHB-Lite slave front end of the flash option and protection block.
// Assumes a single master; writes finish with no wait, reads take one wait state.
`timescale 1ns/1ps
module fop_ahb_slave import fop_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	input wire logic [31:0] rd_data_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	output fop_bus_wr_t wr_out,
	output logic [7:0] rd_addr_out
);
	fop_ahb_st_t s_q, s_d;
	logic take;

	// Read data is registered so that hrdata never ripples with the register mux.
	always_comb begin
		take = hsel_in && (htrans_in == HTRANS_NONSEQ) && hready_in;
		s_d = s_q;
		s_d.wr_pend = take && hwrite_in;
		s_d.rd_pend = take && !hwrite_in;
		if (take) begin
			s_d.addr = haddr_in[7:0];
			s_d.hit = (haddr_in[31:8] == 24'h000000) && (hsize_in == HSIZE_WORD);
		end
		if (s_q.rd_pend) begin
			s_d.hrdata = s_q.hit ? rd_data_in : 32'h00000000;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign wr_out = '{en: s_q.wr_pend && s_q.hit, addr: s_q.addr, data: hwdata_in};
	assign rd_addr_out = s_q.addr;
	assign hrdata_out = s_q.hrdata;
	assign hreadyout_out = !s_q.rd_pend;
	assign hresp_out = 1'b0;
endmodule

//--- src/fop_guard.sv
// Combinational protection check for one requested flash operation.
// Assumes the option byte and protection registers are already latched by the caller.
`timescale 1ns/1ps
module fop_guard import fop_pkg::*; (
	input wire logic [2:0] cmd_in,
	input wire logic [15:0] addr_in,
	input wire logic [6:0] page_in,
	input wire logic [7:0] sect_prot_in,
	input wire logic unlocked_in,
	input wire logic [7:0] opts_in,
	input wire logic from_dbg_in,
	output logic allowed_out
);
	logic in_pmem, info_ok, page_ok, sect_ok, wp_ok;

	always_comb begin
		in_pmem = addr_in <= PMEM_LAST;
		// RULE1: partial info access
		info_ok = (addr_in >= INFO_BASE) && (addr_in <= INFO_LAST) && (addr_in <= INFO_ACC_LAST);
		// RULE3: page and sector
		page_ok = addr_in[15:PAGE_LSB] == page_in;
		sect_ok = !sect_prot_in[addr_in[SECT_MSB:SECT_LSB]];
		// RULE10: write protect open
		wp_ok = opts_in[OPT_WP_BIT];
		case (cmd_in)
			CMD_READ: begin
				allowed_out = in_pmem || info_ok;
			end
			// RULE3: full memory key
			CMD_PROG, CMD_PERASE: begin
				allowed_out = wp_ok && unlocked_in && in_pmem && page_ok && sect_ok;
			end
			// RULE9: debug erase bypass
			CMD_MERASE: begin
				allowed_out = from_dbg_in || (wp_ok && unlocked_in && (sect_prot_in == 8'h00));
			end
			default: begin
				allowed_out = 1'b0;
			end
		endcase
	end
endmodule

//--- src/fop_flash_ctrl.sv
// Flash sequencer with option byte protection, register file and array strobes.
// Assumes a synchronous array that returns read data one cycle after rd, holds its
// program and erase strobes as levels, and a debug port on this same clock.
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module fop_flash_ctrl import fop_pkg::*; #(
	parameter int unsigned PERASE_CYCLES = PERASE_CYC,
	parameter int unsigned MERASE_CYCLES = MERASE_CYC
) (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	output fop_flash_req_t flash_req_out,
	input wire logic [7:0] flash_rdata_in,
	input wire logic dbg_mass_erase_in,
	input wire logic stop_mode_in,
	input wire logic bo_stop_off_in,
	output logic brownout_en_out,
	output logic dbg_code_read_en_out,
	output logic dbg_full_cmd_en_out,
	output logic opt_valid_out
);
	fop_ctrl_st_t s_q, s_d;
	fop_bus_wr_t bus_wr;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic dbg_go, user_go, ctrl_wr, allowed;
	logic [2:0] eval_cmd;
	logic [23:0] chk_len_q;

	fop_ahb_slave u_bus (
		.sys_clk_in(sys_clk_in),
		.reset_n_in(reset_n_in),
		.hsel_in(hsel_in),
		.haddr_in(haddr_in),
		.htrans_in(htrans_in),
		.hwrite_in(hwrite_in),
		.hsize_in(hsize_in),
		.hwdata_in(hwdata_in),
		.hready_in(hready_in),
		.rd_data_in(rd_data),
		.hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out),
		.hresp_out(hresp_out),
		.wr_out(bus_wr),
		.rd_addr_out(rd_addr)
	);

	// RULE12: options consulted first
	fop_guard u_guard (
		.cmd_in(eval_cmd),
		.addr_in(s_q.addr),
		.page_in(s_q.page),
		.sect_prot_in(s_q.sect),
		.unlocked_in(s_q.unlocked),
		.opts_in(s_q.opts),
		.from_dbg_in(dbg_go),
		.allowed_out(allowed)
	);

	// The debug request wins over a software start in the same idle cycle.
	always_comb begin
		ctrl_wr = bus_wr.en && (bus_wr.addr == REG_CTRL);
		dbg_go = (s_q.st == ST_IDLE) && (s_q.dbg_pend || dbg_mass_erase_in);
		user_go = (s_q.st == ST_IDLE) && !dbg_go && ctrl_wr;
		eval_cmd = dbg_go ? CMD_MERASE : bus_wr.data[2:0];
	end

	always_comb begin
		s_d = s_q;
		// RULE4: stop mode switch off
		// RULE5: brownout held on
		s_d.bo_en = s_q.opts[OPT_BO_BIT] | ~(stop_mode_in & bo_stop_off_in);
		// RULE6: debug access gate
		// RULE7: debug fully open
		s_d.rd_en = s_q.opts[OPT_RP_BIT];
		if (bus_wr.en) begin
			case (bus_wr.addr)
				REG_ADDR: begin
					s_d.addr = bus_wr.data[15:0];
				end
				REG_WDATA: begin
					s_d.wdata = bus_wr.data[7:0];
				end
				REG_PAGE: begin
					s_d.page = bus_wr.data[6:0];
				end
				REG_SECT: begin
					s_d.sect = bus_wr.data[7:0];
				end
				// RULE3: two step unlock
				REG_KEY: begin
					if (bus_wr.data[7:0] == KEY_FIRST) begin
						s_d.key_stage = 1'b1;
						s_d.unlocked = 1'b0;
					end else if (s_q.key_stage && (bus_wr.data[7:0] == KEY_SECOND)) begin
						s_d.key_stage = 1'b0;
						s_d.unlocked = 1'b1;
					end else begin
						s_d.key_stage = 1'b0;
						s_d.unlocked = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (dbg_mass_erase_in && !dbg_go) begin
			s_d.dbg_pend = 1'b1;
		end
		case (s_q.st)
			// RULE11: read only load
			ST_LOAD: begin
				s_d.req.rd = 1'b1;
				s_d.req.addr = OPT_ADDR;
				s_d.loading = 1'b1;
				s_d.st = ST_READ;
			end
			// RULE2: start sequencing
			ST_IDLE: begin
				if (dbg_go || user_go) begin
					s_d.cmd = eval_cmd;
					if (dbg_go) begin
						s_d.dbg_pend = 1'b0;
					end
					if (allowed) begin
						s_d.done = 1'b0;
						s_d.refused = 1'b0;
						s_d.req.addr = s_q.addr;
						s_d.req.wdata = s_q.wdata;
						case (eval_cmd)
							CMD_READ: begin
								s_d.req.rd = 1'b1;
								s_d.st = ST_READ;
							end
							CMD_PROG: begin
								s_d.req.prog = 1'b1;
								s_d.cnt = 24'(PROG_CYC - 1);
								s_d.st = ST_RUN;
							end
							CMD_PERASE: begin
								s_d.req.page_erase = 1'b1;
								s_d.cnt = 24'(PERASE_CYCLES - 1);
								s_d.st = ST_RUN;
							end
							default: begin
								s_d.req.mass_erase = 1'b1;
								s_d.cnt = 24'(MERASE_CYCLES - 1);
								s_d.st = ST_RUN;
							end
						endcase
					end else begin
						s_d.refused = 1'b1;
					end
				end
			end
			ST_READ: begin
				s_d.req.rd = 1'b0;
				s_d.st = ST_READ_WAIT;
			end
			// RULE12: latch option byte
			ST_READ_WAIT: begin
				if (s_q.loading) begin
					s_d.opts = flash_rdata_in;
					s_d.opt_valid = 1'b1;
					s_d.loading = 1'b0;
				end else begin
					s_d.rdata = flash_rdata_in;
					s_d.done = 1'b1;
				end
				s_d.st = ST_IDLE;
			end
			// RULE2: strobe timing
			ST_RUN: begin
				if (s_q.cnt == 24'h000000) begin
					s_d.req.prog = 1'b0;
					s_d.req.page_erase = 1'b0;
					s_d.req.mass_erase = 1'b0;
					s_d.done = 1'b1;
					s_d.unlocked = 1'b0;
					s_d.st = ST_IDLE;
				end else begin
					s_d.cnt = s_q.cnt - 24'h000001;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
		// A start written while busy is dropped and reported, never queued.
		if (ctrl_wr && !user_go) begin
			s_d.refused = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_q <= CTRL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		case (rd_addr)
			REG_CTRL: rd_data = {29'h0, s_q.cmd};
			REG_ADDR: rd_data = {16'h0, s_q.addr};
			REG_WDATA: rd_data = {24'h0, s_q.wdata};
			REG_RDATA: rd_data = {24'h0, s_q.rdata};
			REG_STATUS: begin
				rd_data = {16'h0, s_q.opts, 3'h0, s_q.unlocked, s_q.opt_valid,
					s_q.refused, s_q.done, s_q.st != ST_IDLE};
			end
			REG_KEY: rd_data = {31'h0, s_q.unlocked};
			REG_PAGE: rd_data = {25'h0, s_q.page};
			REG_SECT: rd_data = {24'h0, s_q.sect};
			default: rd_data = 32'h00000000;
		endcase
	end

	assign flash_req_out = s_q.req;
	assign brownout_en_out = s_q.bo_en;
	assign dbg_code_read_en_out = s_q.rd_en;
	assign dbg_full_cmd_en_out = s_q.rd_en;
	assign opt_valid_out = s_q.opt_valid;

	// Helper counter that measures how long a program or erase strobe stood.
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			chk_len_q <= 24'h000000;
		end else if (s_q.req.prog || s_q.req.page_erase || s_q.req.mass_erase) begin
			chk_len_q <= chk_len_q + 24'h000001;
		end else begin
			chk_len_q <= 24'h000000;
		end
	end

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	sequence s_load_rd;
		flash_req_out.rd && (flash_req_out.addr == OPT_ADDR);
	endsequence

	sequence s_refused_idle;
		s_q.refused && (s_q.st == ST_IDLE) && !flash_req_out.prog;
	endsequence

	chk_opt_load_seq: assert property ( // RULE12
		(s_q.st == ST_LOAD) |=> s_load_rd ##2 opt_valid_out)
		else $error("option byte not loaded three cycles after reset");

	chk_no_write_load: assert property ( // RULE11
		!opt_valid_out |-> !(flash_req_out.prog || flash_req_out.page_erase ||
		flash_req_out.mass_erase))
		else $error("array written before the option byte was loaded");

	chk_bo_forced_on: assert property ( // RULE5
		(opt_valid_out && s_q.opts[OPT_BO_BIT]) |=> brownout_en_out)
		else $error("brownout disabled although always-on is set");

	chk_bo_stop_off: assert property ( // RULE4
		(opt_valid_out && !s_q.opts[OPT_BO_BIT] && stop_mode_in && bo_stop_off_in)
		|=> !brownout_en_out)
		else $error("brownout stayed on in stop mode with power bit set");

	chk_rp_locked: assert property ( // RULE6
		(opt_valid_out && $past(opt_valid_out) && !s_q.opts[OPT_RP_BIT])
		|-> (!dbg_code_read_en_out && !dbg_full_cmd_en_out))
		else $error("debug port open while code is read protected");

	chk_rp_open: assert property ( // RULE7
		(opt_valid_out && $past(opt_valid_out) && s_q.opts[OPT_RP_BIT])
		|-> (dbg_code_read_en_out && dbg_full_cmd_en_out))
		else $error("debug port limited while code is not protected");

	chk_info_refused: assert property ( // RULE1
		(user_go && (s_q.addr >= INFO_BASE) && (bus_wr.data[2:0] != CMD_READ))
		|=> s_refused_idle)
		else $error("program or erase accepted in information area");

	chk_sect_refused: assert property ( // RULE3
		(user_go && s_q.sect[s_q.addr[SECT_MSB:SECT_LSB]] &&
		((bus_wr.data[2:0] == CMD_PROG) || (bus_wr.data[2:0] == CMD_PERASE)))
		|=> s_refused_idle)
		else $error("operation accepted in a protected sector");

	chk_wp_user: assert property ( // RULE9
		(user_go && !s_q.opts[OPT_WP_BIT] && (bus_wr.data[2:0] >= CMD_PROG) &&
		(bus_wr.data[2:0] <= CMD_MERASE)) |=> s_refused_idle ##1 !flash_req_out.mass_erase)
		else $error("user program or erase accepted under write protect");

	chk_dbg_erase: assert property ( // RULE9
		dbg_go |=> flash_req_out.mass_erase [*2])
		else $error("debug mass erase not started");

	chk_wp_open: assert property ( // RULE10
		(user_go && s_q.opts[OPT_WP_BIT] && s_q.unlocked && (bus_wr.data[2:0] == CMD_PROG)
		&& (s_q.addr <= PMEM_LAST) && (s_q.addr[15:PAGE_LSB] == s_q.page) &&
		!s_q.sect[s_q.addr[SECT_MSB:SECT_LSB]]) |=> flash_req_out.prog && !s_q.refused)
		else $error("permitted byte program was refused");

	chk_prog_time: assert property ( // RULE2
		$fell(flash_req_out.prog) |-> (chk_len_q == 24'(PROG_CYC)))
		else $error("program strobe length wrong");

	chk_erase_time: assert property ( // RULE2
		$fell(flash_req_out.page_erase) |-> (chk_len_q == 24'(PERASE_CYCLES)))
		else $error("page erase strobe length wrong");

	// These watch the array strobes themselves, so a debug-started erase meets the same limits.
	chk_merase_time: assert property ( // RULE2
		$fell(flash_req_out.mass_erase) |-> (chk_len_q == 24'(MERASE_CYCLES)))
		else $error("mass erase strobe length wrong");

	chk_rd_pulse: assert property ( // RULE2
		flash_req_out.rd |=> !flash_req_out.rd)
		else $error("array read strobe stood longer than one cycle");

	chk_one_strobe: assert property ( // RULE2
		$onehot0({flash_req_out.rd, flash_req_out.prog, flash_req_out.page_erase,
		flash_req_out.mass_erase}))
		else $error("more than one array strobe at a time");

	chk_info_untouched: assert property ( // RULE1
		(flash_req_out.prog || flash_req_out.page_erase)
		|-> (flash_req_out.addr <= PMEM_LAST))
		else $error("program or page erase outside program memory");

	chk_opts_stable: assert property ( // RULE11
		(opt_valid_out && $past(opt_valid_out)) |-> $stable(s_q.opts))
		else $error("latched option byte changed without a reset");

	chk_end_relock: assert property ( // RULE3
		($fell(flash_req_out.prog) || $fell(flash_req_out.page_erase) ||
		$fell(flash_req_out.mass_erase)) |-> (s_q.done && !s_q.unlocked))
		else $error("sequencer still unlocked after an operation");
endmodule

//--- sim/fop_array_model.sv
// Behavioural byte array on the far side of the flash sequencer.
// Assumes reads answer one cycle after the read strobe and the option byte comes from opt_in.
`timescale 1ns/1ps
module fop_array_model import fop_pkg::*; #(
	parameter logic [7:0] TRIM = 8'h3c
) (
	input wire logic sys_clk_in,
	input wire fop_flash_req_t req_in,
	input wire logic [7:0] opt_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem [0:16383];
	fop_flash_req_t prev_q;
	initial begin
		rdata_out = 8'h00;
		prev_q = '0;
		foreach (mem[i]) mem[i] = 8'hff;
	end
	always @(posedge sys_clk_in) begin
		prev_q <= req_in;
		if (req_in.rd) begin
			if (req_in.addr == OPT_ADDR) rdata_out <= opt_in;
			else if (req_in.addr >= INFO_BASE) rdata_out <= TRIM;
			else rdata_out <= mem[req_in.addr[13:0]];
		end else begin
			// The lines are not held between reads, so a sample one cycle late sees inverted data.
			rdata_out <= ~rdata_out;
		end
		// A program pulse can only clear bits, as in a real cell.
		if (req_in.prog && !prev_q.prog)
			mem[req_in.addr[13:0]] <= mem[req_in.addr[13:0]] & req_in.wdata;
		if (req_in.page_erase && !prev_q.page_erase)
			for (int i = 0; i < 512; i++) mem[{req_in.addr[13:9], i[8:0]}] <= 8'hff;
		if (req_in.mass_erase && !prev_q.mass_erase)
			foreach (mem[i]) mem[i] <= 8'hff;
	end
endmodule

//--- sim/flash_option_protection_tb_top.sv
// Self-checking bench of the flash sequencer and its option byte protection.
// Assumes the array model beside the design and erase times cut to a few cycles.
`timescale 1ns/1ps
module flash_option_protection_tb_top import fop_pkg::*;;
	localparam int PE = 20;
	localparam int ME = 30;
	logic clk, rst_n, hsel, hwrite, hready, hresp, dbg_me, stop_m, bo_off;
	logic bo_en, rd_en, full_en, opt_v;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [7:0] frd, opt_byte;
	fop_flash_req_t req;
	int n_mismatch, total_checks;
	fop_flash_ctrl #(.PERASE_CYCLES(PE), .MERASE_CYCLES(ME)) dut_u (
		.sys_clk_in(clk), .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.flash_req_out(req), .flash_rdata_in(frd), .dbg_mass_erase_in(dbg_me),
		.stop_mode_in(stop_m), .bo_stop_off_in(bo_off), .brownout_en_out(bo_en),
		.dbg_code_read_en_out(rd_en), .dbg_full_cmd_en_out(full_en), .opt_valid_out(opt_v));
	fop_array_model arr_u (.sys_clk_in(clk), .req_in(req), .opt_in(opt_byte), .rdata_out(frd));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_rdy();
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (hready === 1'b1) return;
		end
		n_mismatch++;
		end_sim();
	endtask
	// Address phase, then data phase; read data is taken at the closing edge.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
		chk(hresp, 1'b0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic unlock();
		wr(REG_KEY, {24'h0, KEY_FIRST});
		wr(REG_KEY, {24'h0, KEY_SECOND});
	endtask
	task automatic cnt(input logic [2:0] c, output int n);
		logic s;
		n = 0;
		for (int i = 0; i < 2100; i++) begin
			@(posedge clk);
			s = c == CMD_READ ? req.rd : c == CMD_PROG ? req.prog :
				c == CMD_PERASE ? req.page_erase : req.mass_erase;
			if (s === 1'b1) n++;
			else if (n > 0 || i > 3) break;
		end
		if (s === 1'b1) begin
			n_mismatch++;
			end_sim();
		end
	endtask
	task automatic op(input logic [2:0] c, input int len, input logic refd);
		int n;
		wr(REG_CTRL, {29'h0, c});
		cnt(c, n);
		chk(n, len);
		repeat (3) @(posedge clk);
		rd(REG_STATUS);
		chk({q[2], q[0]}, {refd, 1'b0});
		if (!refd && c != CMD_READ) chk(q[4], 1'b0);
	endtask
	task automatic do_reset(input logic [7:0] o);
		opt_byte <= o;
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 20 && opt_v !== 1'b1; i++) @(posedge clk);
		chk(opt_v, 1'b1);
		if (opt_v !== 1'b1) end_sim();
		// The debug and brown-out enables follow the latched option byte one cycle later.
		@(posedge clk);
	endtask
	task automatic t_erased();
		do_reset(8'hff);
		chk({bo_en, rd_en, full_en}, 3'h7);
		stop_m <= 1'b1;
		bo_off <= 1'b1;
		repeat (3) @(posedge clk);
		chk(bo_en, 1'b1);
		stop_m <= 1'b0;
		bo_off <= 1'b0;
		rd(REG_STATUS);
		chk({q[15:8], q[3]}, 9'h1ff);
		rd(8'h40);
		chk(q, 32'h0);
		$display("test erased options done");
	endtask
	task automatic t_prog();
		unlock();
		wr(REG_PAGE, 32'h0);
		wr(REG_SECT, 32'h0);
		wr(REG_ADDR, 32'h10);
		wr(REG_WDATA, 32'h5a);
		op(CMD_PROG, PROG_CYC, 1'b0);
		op(CMD_READ, 1, 1'b0);
		rd(REG_RDATA);
		chk(q, 32'h5a);
		unlock();
		op(CMD_PERASE, PE, 1'b0);
		op(CMD_READ, 1, 1'b0);
		rd(REG_RDATA);
		chk(q, 32'hff);
		unlock();
		op(CMD_MERASE, ME, 1'b0);
		$display("test program and erase done");
	endtask
	task automatic t_guard();
		op(CMD_PROG, 0, 1'b1);
		wr(REG_SECT, 32'h1);
		unlock();
		op(CMD_PROG, 0, 1'b1);
		unlock();
		op(CMD_MERASE, 0, 1'b1);
		wr(REG_SECT, 32'h0);
		wr(REG_PAGE, 32'h1);
		unlock();
		op(CMD_PROG, 0, 1'b1);
		wr(REG_PAGE, 32'h7f);
		wr(REG_ADDR, 32'hfe10);
		unlock();
		op(CMD_PROG, 0, 1'b1);
		op(CMD_READ, 1, 1'b0);
		rd(REG_RDATA);
		chk(q, 32'h3c);
		wr(REG_ADDR, 32'hfe80);
		op(CMD_READ, 0, 1'b1);
		$display("test protection done");
	endtask
	task automatic t_opts();
		int n;
		do_reset(8'hf2);
		chk({bo_en, rd_en, full_en}, 3'h4);
		stop_m <= 1'b1;
		repeat (3) @(posedge clk);
		chk(bo_en, 1'b1);
		bo_off <= 1'b1;
		repeat (3) @(posedge clk);
		chk(bo_en, 1'b0);
		stop_m <= 1'b0;
		bo_off <= 1'b0;
		repeat (3) @(posedge clk);
		chk(bo_en, 1'b1);
		wr(REG_PAGE, 32'h0);
		wr(REG_SECT, 32'h0);
		wr(REG_ADDR, 32'h10);
		unlock();
		op(CMD_PROG, 0, 1'b1);
		unlock();
		op(CMD_MERASE, 0, 1'b1);
		dbg_me <= 1'b1;
		@(posedge clk);
		dbg_me <= 1'b0;
		cnt(CMD_MERASE, n);
		chk(n, ME);
		do_reset(8'hf2);
		rd(REG_STATUS);
		chk(q[15:8], 8'hf2);
		chk(rd_en, 1'b0);
		$display("test option bits done");
	endtask
	initial begin
		rst_n = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = HSIZE_WORD;
		hwdata = 32'h0;
		dbg_me = 1'b0;
		stop_m = 1'b0;
		bo_off = 1'b0;
		opt_byte = 8'hff;
		n_mismatch = 0;
		total_checks = 0;
		t_erased();
		t_prog();
		t_guard();
		t_opts();
		end_sim();
	end
endmodule
